// *** common/scam_defs.svh ***
// Constants of the supervisor control and auto-mask register group.
// Assumes an 8-bit register address space and a 25 MHz core clock.
//
// What this block does
// - Miscellaneous control register lives at register offset 0x9F.
// - Writing one to control bit 7 starts the built-in self-test.
// - While control bit 5 is one, the reset output is driven low.
// - Control bits 2:0 pick release delay 200us,1,10,16,20,70,100,200ms.
// - Power-up auto-mask at 0xA1 hides fast faults of chosen channels.
// - Power-down auto-mask at 0xA2 hides fast faults of chosen channels.
// - Sleep-exit auto-mask at 0xA3 hides fast faults of chosen channels.
// - Sleep-entry auto-mask at 0xA4 hides fast faults of chosen channels.
// - In every auto-mask register channel n sits at bit n-1; one enables.
// - Auto-mask bits of channels five to eight reset to zero; others preset.
// - Bank select at 0xF0, bit 0 picks bank; bits 7:1 read zero.
// - Activate pin high puts the device in active monitoring.
// - Activate pin low puts the device in shutdown.
// - Interrupt output goes low when a fault is recorded in the flags.
// - A flag clears only when the host writes one to it.
// - Flags stay set after the fault disappears; never self-cleared.
`ifndef SCAM_DEFS_SVH
`define SCAM_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCAM_OFF_MISC 8'h9F
`define SCAM_OFF_AM_PU 8'hA1
`define SCAM_OFF_AM_PD 8'hA2
`define SCAM_OFF_AM_SX 8'hA3
`define SCAM_OFF_AM_SN 8'hA4
`define SCAM_OFF_FLT1 8'hB8
`define SCAM_OFF_FLT2 8'hB9
`define SCAM_OFF_BANK 8'hF0

// ----------------------------------------
// Field positions and write masks
// ----------------------------------------
`define SCAM_BIT_BIST 7
`define SCAM_BIT_HRST 5
`define SCAM_MISC_WMASK 8'hA7
`define SCAM_BANK_WMASK 8'h01

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCAM_RST_MISC 8'h00
`define SCAM_RST_AM_HI 4'h0
`define SCAM_RST_ZERO 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCAM_CLK_MHZ 25
`define SCAM_DLY0_US 200
`define SCAM_DLY1_US 1000
`define SCAM_DLY2_US 10000
`define SCAM_DLY3_US 16000
`define SCAM_DLY4_US 20000
`define SCAM_DLY5_US 70000
`define SCAM_DLY6_US 100000
`define SCAM_DLY7_US 200000
`define SCAM_CNT_W 23

`endif

// *** common/scam_pkg.sv ***
// Types shared by the supervisor control and auto-mask register group.
// Assumes the constants header is compiled alongside.
package scam_pkg;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scam_req_t;

  typedef struct packed {
    logic [7:0] ov;
    logic [7:0] uv;
  } scam_fault_t;

  typedef struct packed {
    logic power_up;
    logic power_down;
    logic sleep_exit;
    logic sleep_entry;
  } scam_trans_t;

  // ----------------------------------------
  // State machines
  // ----------------------------------------
  typedef enum logic [1:0] {
    PWR_SHUTDOWN_STATE = 2'b01,
    PWR_ACTIVE = 2'b10
  } scam_pwr_t;

  typedef enum logic [2:0] {
    RO_IDLE = 3'b001,
    RO_HOLD = 3'b010,
    RO_RELEASE = 3'b100
  } scam_rout_t;

endpackage

// *** src/scam_regs.sv ***
// Control and auto-mask register group of a multichannel supervisor.
// Assumes the serial front end delivers one-cycle register strobes.
`timescale 1ns/100ps
`include "scam_defs.svh"

module scam_regs
  import scam_pkg::*;
#(
  parameter logic [3:0] AM_LO_INIT = 4'h0,
  parameter logic [2:0] DLY_INIT = 3'h0,
  parameter logic BANK_INIT = 1'b0,
  parameter int unsigned DLY_DIV = 1 // Divides all release delays; keep at one in silicon.
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic srst_i,
  // Register access.
  input wire scam_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // Monitor side.
  input wire scam_fault_t fault_i,
  input wire scam_trans_t trans_i,
  input wire logic activate_pin_i,
  // Open-drain reset pin.
  input wire logic reset_out_n_i,
  output logic reset_out_n_o,
  output logic reset_out_n_oe_o,
  // Open-drain interrupt pin.
  input wire logic fault_irq_n_i,
  output logic fault_irq_n_o,
  output logic fault_irq_n_oe_o,
  // Status toward the rest of the device.
  output logic self_test_request_o,
  output logic shutdown_state_o,
  output logic bank_select_o
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] misc_control;
  logic [7:0] automask_power_up;
  logic [7:0] automask_power_down;
  logic [7:0] automask_sleep_exit;
  logic [7:0] automask_sleep_entry;
  logic [7:0] register_page_select;
  logic [7:0] fault_flags_first;
  logic [7:0] fault_flags_second;
  logic [7:0] suppress;
  logic [7:0] next_ff1;
  logic [7:0] next_ff2;
  logic [7:0] clr1;
  logic [7:0] clr2;
  logic recording;
  scam_pwr_t pwr_state;
  scam_rout_t ro_state;
  scam_rout_t next_ro;
  logic [`SCAM_CNT_W-1:0] ro_cnt;
  logic irq_drive;

  // Write strobes per register.
  wire w_misc = reg_req_i.wr && (reg_req_i.addr == `SCAM_OFF_MISC);
  wire w_pu = reg_req_i.wr && (reg_req_i.addr == `SCAM_OFF_AM_PU);
  wire w_pd = reg_req_i.wr && (reg_req_i.addr == `SCAM_OFF_AM_PD);
  wire w_sx = reg_req_i.wr && (reg_req_i.addr == `SCAM_OFF_AM_SX);
  wire w_sn = reg_req_i.wr && (reg_req_i.addr == `SCAM_OFF_AM_SN);
  wire w_bank = reg_req_i.wr && (reg_req_i.addr == `SCAM_OFF_BANK);
  wire w_f1 = reg_req_i.wr && (reg_req_i.addr == `SCAM_OFF_FLT1);
  wire w_f2 = reg_req_i.wr && (reg_req_i.addr == `SCAM_OFF_FLT2);

  // Maps the delay code onto its cycle count.
  function automatic logic [`SCAM_CNT_W-1:0] dly_cycles(input logic [2:0] code);
    case (code)
      3'h0: return `SCAM_CNT_W'(`SCAM_DLY0_US * `SCAM_CLK_MHZ / DLY_DIV);
      3'h1: return `SCAM_CNT_W'(`SCAM_DLY1_US * `SCAM_CLK_MHZ / DLY_DIV);
      3'h2: return `SCAM_CNT_W'(`SCAM_DLY2_US * `SCAM_CLK_MHZ / DLY_DIV);
      3'h3: return `SCAM_CNT_W'(`SCAM_DLY3_US * `SCAM_CLK_MHZ / DLY_DIV);
      3'h4: return `SCAM_CNT_W'(`SCAM_DLY4_US * `SCAM_CLK_MHZ / DLY_DIV);
      3'h5: return `SCAM_CNT_W'(`SCAM_DLY5_US * `SCAM_CLK_MHZ / DLY_DIV);
      3'h6: return `SCAM_CNT_W'(`SCAM_DLY6_US * `SCAM_CLK_MHZ / DLY_DIV);
      default: return `SCAM_CNT_W'(`SCAM_DLY7_US * `SCAM_CLK_MHZ / DLY_DIV);
    endcase
  endfunction

  // Control register; reserved bits never store, so they read as zero.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      misc_control <= `SCAM_RST_MISC | {5'h00, DLY_INIT};
    end else if (w_misc) begin
      misc_control <= reg_req_i.wdata & `SCAM_MISC_WMASK;
    end
  end

  // Auto-mask registers; upper nibble zero, lower nibble preset at reset.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      automask_power_up <= {`SCAM_RST_AM_HI, AM_LO_INIT};
      automask_power_down <= {`SCAM_RST_AM_HI, AM_LO_INIT};
      automask_sleep_exit <= {`SCAM_RST_AM_HI, AM_LO_INIT};
      automask_sleep_entry <= {`SCAM_RST_AM_HI, AM_LO_INIT};
    end else begin
      if (w_pu) begin
        automask_power_up <= reg_req_i.wdata;
      end
      if (w_pd) begin
        automask_power_down <= reg_req_i.wdata;
      end
      if (w_sx) begin
        automask_sleep_exit <= reg_req_i.wdata;
      end
      if (w_sn) begin
        automask_sleep_entry <= reg_req_i.wdata;
      end
    end
  end

  // Bank select holds only bit 0.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      register_page_select <= {7'h00, BANK_INIT};
    end else if (w_bank) begin
      register_page_select <= reg_req_i.wdata & `SCAM_BANK_WMASK;
    end
  end

  // ----------------------------------------
  // Power state from the activate pin
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pwr_state <= PWR_SHUTDOWN_STATE;
    end else begin
      case (pwr_state)
        PWR_SHUTDOWN_STATE: begin
          if (activate_pin_i) begin
            pwr_state <= PWR_ACTIVE;
          end
        end
        PWR_ACTIVE: begin
          if (!activate_pin_i) begin
            pwr_state <= PWR_SHUTDOWN_STATE;
          end
        end
        default: pwr_state <= PWR_SHUTDOWN_STATE;
      endcase
    end
  end

  assign recording = (pwr_state == PWR_ACTIVE);

  // ----------------------------------------
  // Per-channel transition masking
  // ----------------------------------------
  // Channel n is bit n-1 in every auto-mask register.
  for (genvar n = 0; n < 8; n++) begin : g_chan
    assign suppress[n] = (trans_i.power_up & automask_power_up[n])
                       | (trans_i.power_down & automask_power_down[n])
                       | (trans_i.sleep_exit & automask_sleep_exit[n])
                       | (trans_i.sleep_entry & automask_sleep_entry[n]);
  end

  // ----------------------------------------
  // Fault flags
  // ----------------------------------------
  // A new fault in the cycle of its own clear still lands: set wins.
  always_comb begin
    clr1 = w_f1 ? reg_req_i.wdata : 8'h00;
    clr2 = w_f2 ? reg_req_i.wdata : 8'h00;
    next_ff1 = (fault_flags_first & ~clr1)
             | ({8{recording}} & fault_i.uv & ~suppress);
    next_ff2 = (fault_flags_second & ~clr2)
             | ({8{recording}} & fault_i.ov & ~suppress);
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      fault_flags_first <= `SCAM_RST_ZERO;
      fault_flags_second <= `SCAM_RST_ZERO;
    end else begin
      fault_flags_first <= next_ff1;
      fault_flags_second <= next_ff2;
    end
  end

  // Interrupt pin follows the stored flags one cycle later.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_drive <= 1'b0;
    end else begin
      irq_drive <= |{fault_flags_first, fault_flags_second};
    end
  end

  // ----------------------------------------
  // Host reset and release delay
  // ----------------------------------------
  // The delay code is sampled when the request drops, so a later edit of
  // the code does not stretch or cut a release already under way.
  always_comb begin
    next_ro = ro_state;
    case (ro_state)
      RO_IDLE: begin
        if (misc_control[`SCAM_BIT_HRST]) begin
          next_ro = RO_HOLD;
        end
      end
      RO_HOLD: begin
        if (!misc_control[`SCAM_BIT_HRST]) begin
          next_ro = RO_RELEASE;
        end
      end
      RO_RELEASE: begin
        if (misc_control[`SCAM_BIT_HRST]) begin
          next_ro = RO_HOLD;
        end else if (ro_cnt <= `SCAM_CNT_W'(1)) begin
          next_ro = RO_IDLE;
        end
      end
      default: next_ro = RO_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ro_state <= RO_IDLE;
      ro_cnt <= '0;
    end else begin
      ro_state <= next_ro;
      if (ro_state == RO_HOLD) begin
        ro_cnt <= dly_cycles(misc_control[2:0]);
      end else if (ro_cnt != '0) begin
        ro_cnt <= ro_cnt - `SCAM_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------
  // Read port and outputs
  // ----------------------------------------
  // Unmapped offsets read as zero one cycle after the strobe.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `SCAM_OFF_MISC: reg_rdata_o <= misc_control;
        `SCAM_OFF_AM_PU: reg_rdata_o <= automask_power_up;
        `SCAM_OFF_AM_PD: reg_rdata_o <= automask_power_down;
        `SCAM_OFF_AM_SX: reg_rdata_o <= automask_sleep_exit;
        `SCAM_OFF_AM_SN: reg_rdata_o <= automask_sleep_entry;
        `SCAM_OFF_FLT1: reg_rdata_o <= fault_flags_first;
        `SCAM_OFF_FLT2: reg_rdata_o <= fault_flags_second;
        `SCAM_OFF_BANK: reg_rdata_o <= register_page_select;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Open-drain pins only ever pull low; the pad inputs are not needed.
  assign reset_out_n_o = 1'b0;
  assign reset_out_n_oe_o = (ro_state != RO_IDLE);
  assign fault_irq_n_o = 1'b0;
  assign fault_irq_n_oe_o = irq_drive;
  assign self_test_request_o = misc_control[`SCAM_BIT_BIST];
  assign shutdown_state_o = (pwr_state == PWR_SHUTDOWN_STATE);
  assign bank_select_o = register_page_select[0];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [`SCAM_CNT_W-1:0] rel_len;
  logic [`SCAM_CNT_W-1:0] rel_goal;

  always_ff @(posedge mclk_i) begin
    if (srst_i || ro_state != RO_RELEASE) begin
      rel_len <= '0;
      rel_goal <= dly_cycles(misc_control[2:0]);
    end else begin
      rel_len <= rel_len + `SCAM_CNT_W'(1);
    end
  end

  property p_misc_off;
    @(posedge mclk_i) disable iff (srst_i)
      (reg_req_i.rd && reg_req_i.addr == 8'h9F) |=> reg_rdata_o == $past(misc_control);
  endproperty
  a_misc_off: assert property (p_misc_off) else $error("control readback wrong");
  property p_bist;
    @(posedge mclk_i) disable iff (srst_i)
      (w_misc && reg_req_i.wdata[7]) |=> self_test_request_o;
  endproperty
  a_bist: assert property (p_bist) else $error("self-test not requested");
  property p_hold;
    @(posedge mclk_i) disable iff (srst_i)
      $rose(misc_control[5]) |=> reset_out_n_oe_o [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("reset not driven low");
  property p_release_len;
    @(posedge mclk_i) disable iff (srst_i)
      (ro_state == RO_RELEASE && next_ro == RO_IDLE) |-> rel_len + 1 == rel_goal;
  endproperty
  a_release_len: assert property (p_release_len) else $error("release delay wrong");
  // A suppressed channel must gain no new flag, whatever the other channels do.
  property p_mask;
    @(posedge mclk_i) disable iff (srst_i)
      (|suppress) |=> (((fault_flags_first & ~$past(fault_flags_first))
        | (fault_flags_second & ~$past(fault_flags_second))) & $past(suppress)) == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("masked fault recorded");
  property p_bank;
    @(posedge mclk_i) disable iff (srst_i)
      (reg_req_i.rd && reg_req_i.addr == 8'hF0) |=> reg_rdata_o[7:1] == 7'h00;
  endproperty
  a_bank: assert property (p_bank) else $error("bank reserved bits set");
  property p_shutdown_state;
    @(posedge mclk_i) disable iff (srst_i)
      shutdown_state_o |=> (fault_flags_second & ~$past(fault_flags_second)) == 8'h00;
  endproperty
  a_shutdown_state: assert property (p_shutdown_state) else $error("fault recorded in shutdown");
  property p_sticky;
    @(posedge mclk_i) disable iff (srst_i)
      !w_f2 |=> (fault_flags_second & $past(fault_flags_second)) == $past(fault_flags_second);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");
  property p_irq;
    @(posedge mclk_i) disable iff (srst_i)
      (|{fault_flags_first, fault_flags_second}) |=> fault_irq_n_oe_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not asserted");
  property p_irq_off;
    @(posedge mclk_i) disable iff (srst_i)
      (fault_flags_first == 8'h00 && fault_flags_second == 8'h00) |=> !fault_irq_n_oe_o;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt stuck");

  c_release: cover property (@(posedge mclk_i) ro_state == RO_RELEASE ##1 ro_state == RO_IDLE);
  c_irq: cover property (@(posedge mclk_i) $rose(fault_irq_n_oe_o));
  c_clear: cover property (@(posedge mclk_i) $fell(fault_irq_n_oe_o));
  c_active: cover property (@(posedge mclk_i) $rose(pwr_state == PWR_ACTIVE));

endmodule // scam_regs

// *** sim/scam_host_model.sv ***
// Partner model of the safety controller that sits across the supervisor pins.
// Assumes the bench hands it a wanted activate level; the two open-drain lines
// carry pull-ups on the board.
`timescale 1ns/100ps

module scam_host_model (
  // Clock.
  input wire logic mclk_i,
  // Commands from the bench.
  input wire logic act_cmd_i,
  // Open-drain drivers of the supervisor.
  input wire logic rst_drv_i,
  input wire logic rst_oe_i,
  input wire logic irq_drv_i,
  input wire logic irq_oe_i,
  // Pins as the controller sees them.
  output logic activate_pin_o,
  output logic reset_line_o,
  output logic irq_line_o
);
  // The pin changes just after an edge, as real firmware toggling would.
  initial activate_pin_o = 1'b0;
  always @(posedge mclk_i) begin
    activate_pin_o <= act_cmd_i;
  end

  // A released line floats up to the pull-up, never to a stale value.
  assign reset_line_o = rst_oe_i ? rst_drv_i : 1'b1;
  assign irq_line_o = irq_oe_i ? irq_drv_i : 1'b1;
endmodule // scam_host_model

// *** sim/testbench.sv ***
// Self-checking bench for the control and auto-mask register group.
// Assumes the short delay counts set below and a 25 MHz clock.
`timescale 1ns/100ps
`include "scam_defs.svh"

module testbench;
  import scam_pkg::*;

  // Release delays shrink by this divider so that the longest code stays short.
  localparam int unsigned DLY_DIV = 2500;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic mclk_i;
  logic srst_i;
  logic act_cmd;
  scam_req_t req;
  scam_fault_t flt;
  scam_trans_t trn;
  logic [7:0] rdata;
  logic act_pin, rst_line, irq_line;
  logic rst_drv, rst_oe, irq_drv, irq_oe, bist, shutdown_state, bank;
  int failures;
  int cmp_count;
  int n;

  // ----------------------------------------
  // Design and partner
  // ----------------------------------------
  scam_regs #(.AM_LO_INIT(4'hA), .DLY_DIV(DLY_DIV)) dut_u (
    .mclk_i(mclk_i), .srst_i(srst_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .fault_i(flt), .trans_i(trn), .activate_pin_i(act_pin),
    .reset_out_n_i(rst_line), .reset_out_n_o(rst_drv), .reset_out_n_oe_o(rst_oe),
    .fault_irq_n_i(irq_line), .fault_irq_n_o(irq_drv), .fault_irq_n_oe_o(irq_oe),
    .self_test_request_o(bist), .shutdown_state_o(shutdown_state), .bank_select_o(bank));

  scam_host_model host_u (.mclk_i(mclk_i), .act_cmd_i(act_cmd), .rst_drv_i(rst_drv),
    .rst_oe_i(rst_oe), .irq_drv_i(irq_drv), .irq_oe_i(irq_oe), .activate_pin_o(act_pin),
    .reset_line_o(rst_line), .irq_line_o(irq_line));

  // Free-running core clock.
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Release length in cycles of one delay code, from the documented times.
  function automatic int exp_release(input int code);
    int us;
    case (code)
      0: us = `SCAM_DLY0_US;
      1: us = `SCAM_DLY1_US;
      2: us = `SCAM_DLY2_US;
      3: us = `SCAM_DLY3_US;
      4: us = `SCAM_DLY4_US;
      5: us = `SCAM_DLY5_US;
      6: us = `SCAM_DLY6_US;
      default: us = `SCAM_DLY7_US;
    endcase
    return us * `SCAM_CLK_MHZ / DLY_DIV;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Strobes last exactly one cycle; the request is taken on the second edge.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk_i);
    req.wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk_i);
    req.rd <= 1'b0;
    @(negedge mclk_i);
    check(rdata, exp);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  // Holds a fault pattern for a few cycles and then removes it.
  task automatic pulse_fault(input logic [7:0] uv, input logic [7:0] ov);
    @(posedge mclk_i);
    flt <= '{ov: ov, uv: uv};
    repeat (3) @(posedge mclk_i);
    flt <= '{ov: 8'h00, uv: 8'h00};
    settle(2);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    failures = 0;
    cmp_count = 0;
    srst_i = 1'b1;
    act_cmd = 1'b0;
    req = '0;
    flt = '0;
    trn = '0;
    repeat (6) @(posedge mclk_i);
    srst_i <= 1'b0;
    // Reset values, with the channel one to four preset set to 0xA.
    reg_rd(8'h9F, 8'h00);
    for (int i = 0; i < 4; i++) begin
      reg_rd(8'hA1 + i[7:0], 8'h0A);
    end
    reg_rd(8'hF0, 8'h00);
    reg_rd(8'h10, 8'h00);
    check({7'h0, shutdown_state}, 8'h01);
    // Every auto-mask register stores all eight channel bits.
    for (int i = 0; i < 4; i++) begin
      reg_wr(8'hA1 + i[7:0], 8'hC3);
      reg_rd(8'hA1 + i[7:0], 8'hC3);
    end
    reg_wr(8'hF0, 8'hFF);
    reg_rd(8'hF0, 8'h01);
    check({7'h0, bank}, 8'h01);
    reg_wr(8'h9F, 8'hFF);
    reg_rd(8'h9F, 8'hA7);
    check({7'h0, bist}, 8'h01);
    // Held reset, then release after the delay of each code.
    for (int c = 0; c < 8; c++) begin
      reg_wr(8'h9F, 8'h20 | c[7:0]);
      settle(3);
      check({7'h0, rst_line}, 8'h00);
      reg_wr(8'h9F, c[7:0]);
      n = 0;
      @(negedge mclk_i);
      while (rst_oe === 1'b1 && n < 3000) begin
        n++;
        @(negedge mclk_i);
      end
      if (n >= 3000) begin
        failures++;
        wrap_up();
      end
      // One held cycle is seen before the release count starts.
      check(n[15:0], 16'(exp_release(c) + 1));
    end
    check({7'h0, bist}, 8'h00);
    // Active state, two faults recorded and cleared one at a time.
    @(posedge mclk_i);
    act_cmd <= 1'b1;
    settle(4);
    check({7'h0, shutdown_state}, 8'h00);
    pulse_fault(8'h01, 8'h80);
    check({7'h0, irq_line}, 8'h00);
    reg_rd(8'hB8, 8'h01);
    reg_rd(8'hB9, 8'h80);
    reg_wr(8'hB8, 8'h00);
    reg_rd(8'hB8, 8'h01);
    reg_wr(8'hB8, 8'h01);
    settle(2);
    check({7'h0, irq_oe}, 8'h01);
    reg_rd(8'hB8, 8'h00);
    reg_wr(8'hB9, 8'h80);
    settle(2);
    check({7'h0, irq_line}, 8'h01);
    // Channel two masked in each transition; channel three still reports.
    for (int i = 0; i < 4; i++) begin
      reg_wr(8'hA1 + i[7:0], 8'h02);
      trn <= 4'(4'h8 >> i);
      pulse_fault(8'h06, 8'h02);
      @(posedge mclk_i);
      trn <= '0;
      reg_rd(8'hB8, 8'h04);
      reg_rd(8'hB9, 8'h00);
      reg_wr(8'hB8, 8'h04);
    end
    // Shutdown ignores faults.
    act_cmd <= 1'b0;
    settle(4);
    check({7'h0, shutdown_state}, 8'h01);
    pulse_fault(8'hFF, 8'hFF);
    reg_rd(8'hB8, 8'h00);
    check({7'h0, irq_oe}, 8'h00);
    wrap_up();
  end
endmodule // testbench
